/* File: tdb_pkg.sv */
// package: register map, field layout and carriers of the tile debug register set
package tdb_pkg;

   // ==========================================================
   // sizes
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned NUM_THREADS = 8;
   localparam int unsigned THREAD_W    = 3;
   localparam int unsigned NUM_IBRK    = 4;
   localparam int unsigned UNIT_W      = 2;
   localparam int unsigned NUM_SCRATCH = 8;
   localparam int unsigned SCR_IDX_W   = 3;

   // ==========================================================
   // register indices
   localparam logic [7:0] OFS_MEM_SIZE  = 8'h0c;
   localparam logic [7:0] OFS_SSR       = 8'h10;
   localparam logic [7:0] OFS_SPC       = 8'h11;
   localparam logic [7:0] OFS_SSP       = 8'h12;
   localparam logic [7:0] OFS_RR_THREAD = 8'h13;
   localparam logic [7:0] OFS_RR_REG    = 8'h14;
   localparam logic [7:0] OFS_CAUSE     = 8'h15;
   localparam logic [7:0] OFS_INFO      = 8'h16;
   localparam logic [7:0] OFS_RUN_INH   = 8'h18;
   localparam logic [7:0] OFS_SCRATCH   = 8'h20;
   localparam logic [7:0] OFS_IBRK_ADDR = 8'h30;
   localparam logic [7:0] OFS_IBRK_CTRL = 8'h40;
   localparam logic [7:0] OFS_DWATCH    = 8'h50;

   // ==========================================================
   // field layout
   localparam logic [31:0] SSR_WR_MASK    = 32'h0000_06df;
   localparam logic [31:0] SSR_KEEP_MASK  = 32'h0000_07df;
   localparam logic [31:0] RR_THREAD_MASK = 32'h0000_00ff;
   localparam logic [31:0] RR_REG_MASK    = 32'h0000_001f;
   localparam logic [31:0] RUN_INH_MASK   = 32'h0000_00ff;
   localparam logic [31:0] CAUSE_MASK     = 32'h0003_ff07;
   localparam logic [31:0] IBRK_CTRL_MASK = 32'h00ff_0003;
   localparam logic [31:0] MEM_LOW_MASK   = 32'hffff_fffc;
   localparam int unsigned CAUSE_LSB      = 0;
   localparam int unsigned CAUSE_THR_LSB  = 8;
   localparam int unsigned CAUSE_UNIT_LSB = 16;
   localparam int unsigned IBRK_EN_BIT    = 0;
   localparam int unsigned IBRK_NEQ_BIT   = 1;
   localparam int unsigned IBRK_THR_LSB   = 16;

   // ==========================================================
   // cause codes
   localparam logic [2:0] CAUSE_NONE   = 3'h0;
   localparam logic [2:0] CAUSE_HOST   = 3'h1;
   localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION  = 3'h2;
   localparam logic [2:0] CAUSE_IBRK   = 3'h3;
   localparam logic [2:0] CAUSE_DWATCH = 3'h4;
   localparam logic [2:0] CAUSE_RWATCH = 3'h5;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } tdb_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] saved_status_word;
      logic [31:0] saved_program_counter;
      logic [31:0] saved_stack_pointer;
   } tdb_entry_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  thread;
      logic [31:0] pc;
   } tdb_pc_t;

   typedef struct packed {
      logic [3:0]  hit;
      logic [2:0]  thread;
      logic [31:0] info;
   } tdb_watch_t;

endpackage : tdb_pkg

/* File: tdb_debug_regs.sv */
// tile debug state, cause capture, scratch and instruction breakpoint registers
// What this block does
// - read-only memory size register, bits 31:2 address top, bits 1:0 reserved.
// - on debugger entry capture saved status word; debugger may read and write it.
// - status bits 7 fast,6 paused,4 kernel,3 irq handler,2 event seq,1 irq,0 events.
// - bit 9 issue mode for kernel entry; bit 8 current issue mode read-only.
// - bit 10 address space id writable; bits 31:11 and 5 read reserved.
// - on debugger entry capture saved program counter, 32-bit, debugger writable.
// - on debugger entry capture saved stack pointer, 32-bit, debugger writable.
// - 3-bit cause field, reset 0: host, call, ibreak, data watch, resource watch.
// - 2-bit unit number field; zero for host and call; lowest unit wins.
// - 8-bit thread field of the interrupt; zero for a host request.
// - data register takes watch address or resource identifier.
// - threads set in 8-bit run-inhibit vector do not run outside debug mode.
// - eight scratch words, also reachable through tile configuration port.
// - four instruction breakpoints with address registers; interrupt on pc match.
// - per-breakpoint 8 thread enable bits, reset 0, gate which threads break.
// - control bit 1 picks sense: 0 equal, 1 not equal; resets 0.
// - control bit 0 enables the breakpoint; resets 0.
// - four 32-bit first-address registers for the data watchpoints.
`timescale 1ns/10ps
module tdb_debug_regs #(
   parameter logic [29:0] MEM_TOP_BITS = 30'h0000_4000
) (
   input  wire logic               core_clk,
   input  wire logic               reset_n,
   input  wire tdb_pkg::tdb_req_t  ps_req,
   output logic [31:0]             ps_rdata_ff,
   output logic                    ps_rvalid_ff,
   input  wire tdb_pkg::tdb_req_t  cfg_req,
   output logic [31:0]             cfg_rdata_ff,
   output logic                    cfg_rvalid_ff,
   input  wire tdb_pkg::tdb_entry_t entry,
   input  wire tdb_pkg::tdb_pc_t   pc_mon,
   input  wire logic               debug_call_instruction_valid,
   input  wire logic [2:0]         debug_call_instruction_thread,
   input  wire logic               host_dbg_req_pin,
   input  wire tdb_pkg::tdb_watch_t dwatch,
   input  wire tdb_pkg::tdb_watch_t rwatch,
   input  wire logic               in_debug,
   output logic                    debug_irq_ff,
   output logic [7:0]              thread_stop_ff,
   output logic [31:0]             ssr_ff,
   output logic [31:0]             spc_ff,
   output logic [31:0]             ssp_ff,
   output logic [7:0]              rr_thread_ff,
   output logic [4:0]              rr_reg_ff
);

   // ==========================================================
   // elaboration checks
   if (tdb_pkg::NUM_THREADS != 8 || tdb_pkg::NUM_IBRK != 4) begin : g_bad_cfg
      $error("tdb_debug_regs: only 8 threads and 4 breakpoints supported");
   end

   // ==========================================================
   // storage
   logic [31:0] scratch_ff   [tdb_pkg::NUM_SCRATCH];
   logic [31:0] ibrk_addr_ff [tdb_pkg::NUM_IBRK];
   logic [31:0] ibrk_ctrl_ff [tdb_pkg::NUM_IBRK];
   logic [31:0] dwatch_ff    [tdb_pkg::NUM_IBRK];
   logic [31:0] cause_ff;
   logic [31:0] info_ff;
   logic [7:0]  run_inh_ff;
   logic        host_meta_ff;
   logic        host_sync_ff;
   logic        host_prev_ff;

   // ==========================================================
   // decode
   logic        wr_ssr;
   logic        wr_spc;
   logic        wr_ssp;
   logic        wr_cause;
   logic        wr_info;
   logic [3:0]  ibrk_hit;
   logic        host_evt;
   logic        nxt_fire;
   logic [2:0]  nxt_cause;
   logic [1:0]  nxt_unit;
   logic [7:0]  nxt_thread;
   logic [31:0] nxt_info;
   logic [31:0] nxt_ps_rdata;

   assign wr_ssr   = ps_req.wr && ps_req.addr == tdb_pkg::OFS_SSR;
   assign wr_spc   = ps_req.wr && ps_req.addr == tdb_pkg::OFS_SPC;
   assign wr_ssp   = ps_req.wr && ps_req.addr == tdb_pkg::OFS_SSP;
   assign wr_cause = ps_req.wr && ps_req.addr == tdb_pkg::OFS_CAUSE;
   assign wr_info  = ps_req.wr && ps_req.addr == tdb_pkg::OFS_INFO;

   function automatic logic [1:0] lowest_unit(input logic [3:0] hits);
      logic [1:0] u;
      u = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (hits[i]) begin
            u = 2'(i);
         end
      end
      return u;
   endfunction : lowest_unit

   // ==========================================================
   // host request pin synchroniser
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_meta_ff <= 1'b0;
         host_sync_ff <= 1'b0;
         host_prev_ff <= 1'b0;
      end else begin
         host_meta_ff <= host_dbg_req_pin;
         host_sync_ff <= host_meta_ff;
         host_prev_ff <= host_sync_ff;
      end
   end

   assign host_evt = host_sync_ff && !host_prev_ff;

   // ==========================================================
   // breakpoint comparators
   for (genvar i = 0; i < tdb_pkg::NUM_IBRK; i++) begin : g_ibrk
      logic pc_eq;
      assign pc_eq = pc_mon.pc == ibrk_addr_ff[i];
      assign ibrk_hit[i] = pc_mon.valid && !in_debug
         && ibrk_ctrl_ff[i][tdb_pkg::IBRK_EN_BIT]
         && ibrk_ctrl_ff[i][tdb_pkg::IBRK_THR_LSB + 32'(pc_mon.thread)]
         && (ibrk_ctrl_ff[i][tdb_pkg::IBRK_NEQ_BIT] ? !pc_eq : pc_eq);
   end

   // ==========================================================
   // cause selection; host first, then call, breakpoint, watches
   always_comb begin
      nxt_fire   = 1'b1;
      nxt_cause  = tdb_pkg::CAUSE_NONE;
      nxt_unit   = 2'h0;
      nxt_thread = 8'h00;
      nxt_info   = info_ff;
      if (in_debug) begin
         nxt_fire = 1'b0;
      end else if (host_evt) begin
         nxt_cause = tdb_pkg::CAUSE_HOST;
      end else if (debug_call_instruction_valid) begin
         nxt_cause  = tdb_pkg::CAUSE_DEBUG_CALL_INSTRUCTION;
         nxt_thread = {5'h00, debug_call_instruction_thread};
      end else if (|ibrk_hit) begin
         nxt_cause  = tdb_pkg::CAUSE_IBRK;
         nxt_unit   = lowest_unit(ibrk_hit);
         nxt_thread = {5'h00, pc_mon.thread};
      end else if (|dwatch.hit) begin
         nxt_cause  = tdb_pkg::CAUSE_DWATCH;
         nxt_unit   = lowest_unit(dwatch.hit);
         nxt_thread = {5'h00, dwatch.thread};
         nxt_info   = dwatch.info;
      end else if (|rwatch.hit) begin
         nxt_cause  = tdb_pkg::CAUSE_RWATCH;
         nxt_unit   = lowest_unit(rwatch.hit);
         nxt_thread = {5'h00, rwatch.thread};
         nxt_info   = rwatch.info;
      end else begin
         nxt_fire = 1'b0;
      end
   end

   // ==========================================================
   // cause and data capture; hardware event beats a software write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cause_ff     <= 32'h0000_0000;
         info_ff      <= 32'h0000_0000;
         debug_irq_ff <= 1'b0;
      end else begin
         debug_irq_ff <= nxt_fire;
         if (nxt_fire) begin
            cause_ff <= {14'h0000, nxt_unit, nxt_thread, 5'h00, nxt_cause};
            info_ff  <= nxt_info;
         end else begin
            if (wr_cause) begin
               cause_ff <= ps_req.wdata & tdb_pkg::CAUSE_MASK;
            end
            if (wr_info) begin
               info_ff <= ps_req.wdata;
            end
         end
      end
   end

   // ==========================================================
   // saved thread state snapshot; entry beats a debugger write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ssr_ff <= 32'h0000_0000;
         spc_ff <= 32'h0000_0000;
         ssp_ff <= 32'h0000_0000;
      end else if (entry.valid) begin
         ssr_ff <= entry.saved_status_word & tdb_pkg::SSR_KEEP_MASK;
         spc_ff <= entry.saved_program_counter;
         ssp_ff <= entry.saved_stack_pointer;
      end else begin
         if (wr_ssr) begin
            // issue mode bit stays as captured, reserved bits stay zero
            ssr_ff <= (ps_req.wdata & tdb_pkg::SSR_WR_MASK)
                    | (ssr_ff & ~tdb_pkg::SSR_WR_MASK);
         end
         if (wr_spc) begin
            spc_ff <= ps_req.wdata;
         end
         if (wr_ssp) begin
            ssp_ff <= ps_req.wdata;
         end
      end
   end

   // ==========================================================
   // remote read operands and run inhibit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rr_thread_ff <= 8'h00;
         rr_reg_ff    <= 5'h00;
         run_inh_ff   <= 8'h00;
      end else if (ps_req.wr) begin
         if (ps_req.addr == tdb_pkg::OFS_RR_THREAD) begin
            rr_thread_ff <= ps_req.wdata[7:0];
         end
         if (ps_req.addr == tdb_pkg::OFS_RR_REG) begin
            rr_reg_ff <= ps_req.wdata[4:0];
         end
         if (ps_req.addr == tdb_pkg::OFS_RUN_INH) begin
            run_inh_ff <= ps_req.wdata[7:0];
         end
      end
   end

   // stop applies only outside debug mode, so the debugger itself keeps running
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         thread_stop_ff <= 8'h00;
      end else begin
         thread_stop_ff <= in_debug ? 8'h00 : run_inh_ff;
      end
   end

   // ==========================================================
   // per-unit registers and scratch words
   for (genvar i = 0; i < tdb_pkg::NUM_IBRK; i++) begin : g_unit_regs
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            ibrk_addr_ff[i] <= 32'h0000_0000;
            ibrk_ctrl_ff[i] <= 32'h0000_0000;
            dwatch_ff[i]    <= 32'h0000_0000;
         end else if (ps_req.wr) begin
            if (ps_req.addr == tdb_pkg::OFS_IBRK_ADDR + 8'(i)) begin
               ibrk_addr_ff[i] <= ps_req.wdata;
            end
            if (ps_req.addr == tdb_pkg::OFS_IBRK_CTRL + 8'(i)) begin
               ibrk_ctrl_ff[i] <= ps_req.wdata & tdb_pkg::IBRK_CTRL_MASK;
            end
            if (ps_req.addr == tdb_pkg::OFS_DWATCH + 8'(i)) begin
               dwatch_ff[i] <= ps_req.wdata;
            end
         end
      end
   end

   // both ports share one word; the status port wins a same-cycle clash
   for (genvar i = 0; i < tdb_pkg::NUM_SCRATCH; i++) begin : g_scratch
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            scratch_ff[i] <= 32'h0000_0000;
         end else if (ps_req.wr && ps_req.addr == tdb_pkg::OFS_SCRATCH + 8'(i)) begin
            scratch_ff[i] <= ps_req.wdata;
         end else if (cfg_req.wr && cfg_req.addr == tdb_pkg::OFS_SCRATCH + 8'(i)) begin
            scratch_ff[i] <= cfg_req.wdata;
         end
      end
   end

   // ==========================================================
   // read mux of the status port
   always_comb begin
      nxt_ps_rdata = 32'h0000_0000;
      case (ps_req.addr)
         tdb_pkg::OFS_MEM_SIZE:  nxt_ps_rdata = {MEM_TOP_BITS, 2'b00};
         tdb_pkg::OFS_SSR:       nxt_ps_rdata = ssr_ff;
         tdb_pkg::OFS_SPC:       nxt_ps_rdata = spc_ff;
         tdb_pkg::OFS_SSP:       nxt_ps_rdata = ssp_ff;
         tdb_pkg::OFS_RR_THREAD: nxt_ps_rdata = {24'h000000, rr_thread_ff};
         tdb_pkg::OFS_RR_REG:    nxt_ps_rdata = {27'h0000000, rr_reg_ff};
         tdb_pkg::OFS_CAUSE:     nxt_ps_rdata = cause_ff;
         tdb_pkg::OFS_INFO:      nxt_ps_rdata = info_ff;
         tdb_pkg::OFS_RUN_INH:   nxt_ps_rdata = {24'h000000, run_inh_ff};
         default: begin
            if (ps_req.addr[7:3] == tdb_pkg::OFS_SCRATCH[7:3]) begin
               nxt_ps_rdata = scratch_ff[ps_req.addr[2:0]];
            end else if (ps_req.addr[7:2] == tdb_pkg::OFS_IBRK_ADDR[7:2]) begin
               nxt_ps_rdata = ibrk_addr_ff[ps_req.addr[1:0]];
            end else if (ps_req.addr[7:2] == tdb_pkg::OFS_IBRK_CTRL[7:2]) begin
               nxt_ps_rdata = ibrk_ctrl_ff[ps_req.addr[1:0]];
            end else if (ps_req.addr[7:2] == tdb_pkg::OFS_DWATCH[7:2]) begin
               nxt_ps_rdata = dwatch_ff[ps_req.addr[1:0]];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ps_rdata_ff   <= 32'h0000_0000;
         ps_rvalid_ff  <= 1'b0;
         cfg_rdata_ff  <= 32'h0000_0000;
         cfg_rvalid_ff <= 1'b0;
      end else begin
         ps_rvalid_ff  <= ps_req.rd;
         cfg_rvalid_ff <= cfg_req.rd;
         ps_rdata_ff   <= ps_req.rd ? nxt_ps_rdata : 32'h0000_0000;
         if (cfg_req.rd && cfg_req.addr[7:3] == tdb_pkg::OFS_SCRATCH[7:3]) begin
            cfg_rdata_ff <= scratch_ff[cfg_req.addr[2:0]];
         end else begin
            cfg_rdata_ff <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // checks
   property p_ibrk_cause;
      @(posedge core_clk) disable iff (!reset_n)
      (!in_debug && !host_evt && !debug_call_instruction_valid && ibrk_hit[0])
         |=> debug_irq_ff && cause_ff[2:0] == tdb_pkg::CAUSE_IBRK && cause_ff[17:16] == 2'h0;
   endproperty
   a_ibrk_cause: assert property (p_ibrk_cause) else $error("breakpoint 0 not recorded");

   property p_host_thread_zero;
      @(posedge core_clk) disable iff (!reset_n)
      (!in_debug && host_evt) |=> cause_ff[15:8] == 8'h00 && cause_ff[2:0] == tdb_pkg::CAUSE_HOST;
   endproperty
   a_host_thread_zero: assert property (p_host_thread_zero) else $error("host cause bad");

   property p_no_irq_in_debug;
      @(posedge core_clk) disable iff (!reset_n)
      in_debug |=> !debug_irq_ff;
   endproperty
   a_no_irq_in_debug: assert property (p_no_irq_in_debug) else $error("irq in debug");

   property p_entry_capture;
      @(posedge core_clk) disable iff (!reset_n)
      entry.valid |=> spc_ff == $past(entry.saved_program_counter) && ssp_ff == $past(entry.saved_stack_pointer)
         && ssr_ff == ($past(entry.saved_status_word) & tdb_pkg::SSR_KEEP_MASK);
   endproperty
   a_entry_capture: assert property (p_entry_capture) else $error("snapshot missed");

   property p_ssr_reserved;
      @(posedge core_clk) disable iff (!reset_n)
      ssr_ff[31:11] == 21'h000000 && !ssr_ff[5];
   endproperty
   a_ssr_reserved: assert property (p_ssr_reserved) else $error("status reserved set");

   property p_stop_vector;
      @(posedge core_clk) disable iff (!reset_n)
      (ps_req.wr && ps_req.addr == tdb_pkg::OFS_RUN_INH && !in_debug) ##1 !in_debug
         |=> thread_stop_ff == $past(ps_req.wdata[7:0], 2);
   endproperty
   a_stop_vector: assert property (p_stop_vector) else $error("stop vector wrong");

   property p_scratch_cfg;
      @(posedge core_clk) disable iff (!reset_n)
      (cfg_req.wr && !ps_req.wr && cfg_req.addr == tdb_pkg::OFS_SCRATCH)
         ##1 (ps_req.rd && !ps_req.wr && !cfg_req.wr && ps_req.addr == tdb_pkg::OFS_SCRATCH)
         |=> ps_rdata_ff == $past(cfg_req.wdata, 2);
   endproperty
   a_scratch_cfg: assert property (p_scratch_cfg) else $error("scratch not shared");

   property p_mem_size;
      @(posedge core_clk) disable iff (!reset_n)
      (ps_req.rd && ps_req.addr == tdb_pkg::OFS_MEM_SIZE) |=> ps_rvalid_ff && ps_rdata_ff[1:0] == 2'b00
         && ps_rdata_ff[31:2] == MEM_TOP_BITS;
   endproperty
   a_mem_size: assert property (p_mem_size) else $error("memory size wrong");

endmodule : tdb_debug_regs

/* File: tdb_dbg_model.sv */
// debugger-side model: one register access at a time on either port
`timescale 1ns/10ps
module tdb_dbg_model (
   input  wire logic         core_clk,
   input  wire logic [31:0]  ps_rdata_ff,
   input  wire logic         ps_rvalid_ff,
   input  wire logic [31:0]  cfg_rdata_ff,
   input  wire logic         cfg_rvalid_ff,
   output tdb_pkg::tdb_req_t ps_req,
   output tdb_pkg::tdb_req_t cfg_req
);
   initial begin
      ps_req = '0;
      cfg_req = '0;
   end
   // ======================================================
   // held over one edge; idle bus shows inverted values, not stale ones
   task automatic acc(input bit c, input bit wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      tdb_pkg::tdb_req_t r;
      r = '{wr, !wr, a, d};
      @(negedge core_clk);
      if (c) cfg_req = r;
      else ps_req = r;
      @(negedge core_clk);
      r = '{1'b0, 1'b0, ~a, ~d};
      if (c) cfg_req = r;
      else ps_req = r;
      q = (c ? cfg_rvalid_ff : ps_rvalid_ff) ? (c ? cfg_rdata_ff : ps_rdata_ff) : 'x;
   endtask : acc
   // ======================================================
   // operands before a remote read
   task automatic rr_setup(input logic [7:0] thr, input logic [4:0] rg);
      logic [31:0] q;
      acc(1'b0, 1'b1, 8'h13, {24'h0, thr}, q);
      acc(1'b0, 1'b1, 8'h14, {27'h0, rg}, q);
   endtask : rr_setup
endmodule : tdb_dbg_model

/* File: test_tdb_debug_regs.sv */
// self-checking bench for the tile debug register set
`timescale 1ns/10ps
module test_tdb_debug_regs;
   localparam logic [29:0] MTB = 30'h0000_4000;
   logic                core_clk = 1'b0;
   logic                reset_n = 1'b0;
   logic                debug_call_instruction_valid, host_dbg_req_pin, in_debug, debug_irq_ff;
   logic                ps_rvalid_ff, cfg_rvalid_ff;
   logic [2:0]          debug_call_instruction_thread;
   logic [7:0]          thread_stop_ff, rr_thread_ff, t;
   logic [4:0]          rr_reg_ff;
   logic [31:0]         ps_rdata_ff, cfg_rdata_ff, ssr_ff, spc_ff, ssp_ff, q, w, a;
   tdb_pkg::tdb_req_t   ps_req, cfg_req;
   tdb_pkg::tdb_entry_t entry;
   tdb_pkg::tdb_pc_t    pc_mon;
   tdb_pkg::tdb_watch_t dwatch, rwatch;
   int unsigned         miscompares = 0;
   int unsigned         n_tests = 0;

   always #12.5 core_clk = ~core_clk;

   tdb_debug_regs #(.MEM_TOP_BITS(MTB)) DUT (.core_clk, .reset_n, .ps_req, .ps_rdata_ff,
      .ps_rvalid_ff, .cfg_req, .cfg_rdata_ff, .cfg_rvalid_ff, .entry, .pc_mon, .debug_call_instruction_valid,
      .debug_call_instruction_thread, .host_dbg_req_pin, .dwatch, .rwatch, .in_debug, .debug_irq_ff,
      .thread_stop_ff, .ssr_ff, .spc_ff, .ssp_ff, .rr_thread_ff, .rr_reg_ff);
   tdb_dbg_model m (.core_clk, .ps_rdata_ff, .ps_rvalid_ff, .cfg_rdata_ff, .cfg_rvalid_ff,
      .ps_req, .cfg_req);

   // ======================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_tests++;
      if (seen !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk
   function automatic logic [31:0] cw(input logic [2:0] c, input logic [2:0] th,
         input logic [1:0] u);
      return {14'h0, u, 5'h0, th, 5'h0, c};
   endfunction : cw
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      m.acc(1'b0, 1'b1, ad, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
      m.acc(1'b0, 1'b0, ad, 32'h0, q);
      chk(nm, q, e);
   endtask : rd
   // event was set this cycle: flag one cycle on, then cause word
   task automatic fire(input logic i, input logic [31:0] e);
      @(negedge core_clk);
      chk("irq", {31'h0, debug_irq_ff}, {31'h0, i});
      pc_mon.valid = 1'b0;
      debug_call_instruction_valid = 1'b0;
      dwatch.hit = 4'h0;
      rwatch.hit = 4'h0;
      rd("cause", 8'h15, e);
   endtask : fire
   task automatic test_done;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // ======================================================
   // watchdog, far above the few hundred cycles needed
   initial begin
      #125000;
      miscompares++;
      test_done();
   end

   // ======================================================
   // main sequence
   initial begin
      {debug_call_instruction_valid, host_dbg_req_pin, in_debug, debug_call_instruction_thread} = '0;
      {entry, pc_mon, dwatch, rwatch} = '0;
      void'($urandom(32'h7201));
      repeat (12) @(negedge core_clk);
      reset_n = 1'b1;
      rd("cause rst", 8'h15, 32'h0);
      wr(8'h0c, 32'hffff_ffff);
      rd("mem size", 8'h0c, {MTB, 2'b00});
      for (int u = 0; u < 4; u++) rd("ctrl rst", 8'(8'h40 + u), 32'h0);
      w = $urandom;
      wr(8'h10, w);
      rd("ssr", 8'h10, w & 32'h0000_06df);
      entry = '{1'b1, $urandom, $urandom, $urandom};
      @(negedge core_clk);
      chk("ssr_ff", ssr_ff, entry.saved_status_word & 32'h0000_07df);
      chk("spc_ff", spc_ff, entry.saved_program_counter);
      chk("ssp_ff", ssp_ff, entry.saved_stack_pointer);
      entry.valid = 1'b0;
      wr(8'h10, ~entry.saved_status_word);
      rd("ssr b8", 8'h10, (~entry.saved_status_word & 32'h6df) | (entry.saved_status_word & 32'h100));
      wr(8'h11, w);
      rd("spc", 8'h11, w);
      t = 8'($urandom);
      m.rr_setup(t, w[4:0]);
      chk("rr", {19'h0, rr_reg_ff, rr_thread_ff}, {19'h0, w[4:0], t});
      in_debug = 1'b1;
      wr(8'h18, w);
      @(negedge core_clk);
      chk("stop dbg", {24'h0, thread_stop_ff}, 32'h0);
      in_debug = 1'b0;
      @(negedge core_clk);
      chk("stop", {24'h0, thread_stop_ff}, w & 32'hff);
      wr(8'h18, ~w);
      @(negedge core_clk);
      chk("stop live", {24'h0, thread_stop_ff}, ~w & 32'hff);
      for (int i = 0; i < 8; i++) begin
         w = $urandom;
         m.acc(1'b1, 1'b1, 8'(8'h20 + i), w, q);
         rd("scratch", 8'(8'h20 + i), w);
      end
      // config write then status read on the very next cycle
      w = $urandom;
      fork
         m.acc(1'b1, 1'b1, 8'h20, w, q);
         begin
            @(negedge core_clk);
            m.acc(1'b0, 1'b0, 8'h20, 32'h0, a);
         end
      join
      chk("scratch shared", a, w);
      m.acc(1'b1, 1'b0, 8'h20, 32'h0, q);
      chk("cfg scratch", q, w);
      m.acc(1'b1, 1'b0, 8'h10, 32'h0, q);
      chk("cfg unmapped", q, 32'h0);
      for (int u = 0; u < 4; u++) begin
         a = $urandom;
         wr(8'(8'h50 + u), a);
         rd("watch addr", 8'(8'h50 + u), a);
      end
      for (int u = 0; u < 4; u++) begin
         a = $urandom;
         wr(8'(8'h30 + u), a);
         wr(8'(8'h40 + u), 32'h0004_0001);
         @(negedge core_clk);
         pc_mon = '{1'b1, 3'h2, a};
         fire(1'b1, cw(3'h3, 3'h2, u[1:0]));
         pc_mon = '{1'b1, 3'h3, a};
         fire(1'b0, cw(3'h3, 3'h2, u[1:0]));
         wr(8'(8'h40 + u), 32'h0);
      end
      wr(8'h43, 32'h0080_0003);
      @(negedge core_clk);
      pc_mon = '{1'b1, 3'h7, ~a};
      fire(1'b1, cw(3'h3, 3'h7, 2'h3));
      in_debug = 1'b1;
      pc_mon = '{1'b1, 3'h7, ~a};
      fire(1'b0, cw(3'h3, 3'h7, 2'h3));
      in_debug = 1'b0;
      wr(8'h43, 32'h0);
      t = 8'($urandom);
      debug_call_instruction_thread = t[2:0];
      debug_call_instruction_valid = 1'b1;
      fire(1'b1, cw(3'h2, t[2:0], 2'h0));
      a = $urandom;
      dwatch = '{4'h6, t[2:0], a};
      fire(1'b1, cw(3'h4, t[2:0], 2'h1));
      rd("info d", 8'h16, a);
      rwatch = '{4'h8, ~t[2:0], ~a};
      fire(1'b1, cw(3'h5, ~t[2:0], 2'h3));
      rd("info r", 8'h16, ~a);
      host_dbg_req_pin = 1'b1;
      repeat (6) if (debug_irq_ff !== 1'b1) @(negedge core_clk);
      chk("host irq", {31'h0, debug_irq_ff}, 32'h1);
      rd("host", 8'h15, cw(3'h1, 3'h0, 2'h0));
      test_done();
   end
endmodule : test_tdb_debug_regs
